// >>> logic/phcp_pkg.sv
`default_nettype none
package phcp_pkg;
  // synchroniser depth for pins arriving from the host
  localparam int SYNC_STAGES = 3;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 16;
  // status word field positions
  localparam int STAT_PAGE_LSB = 8;
  localparam int STAT_COMMAND_IN_PROGRESS_BIT = 2;
  localparam int STAT_INT_BIT = 1;
  localparam int STAT_WAIT_BIT = 0;
  // reset values
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [1:0] LANE_OE_RST = 2'b00;
  localparam logic [1:0] LANE_OE_WIDE = 2'b11;
  localparam logic [1:0] LANE_OE_NARROW = 2'b01;

  // access decode: {address pin, read}
  typedef enum logic [1:0] {
    ACC_WRITE_DATA = 2'b00,
    ACC_READ_DATA = 2'b01,
    ACC_WRITE_CMD = 2'b10,
    ACC_READ_STATUS = 2'b11
  } phcp_access_t;

  // access state: idle to either strobe phase is one bit change
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WRITE = 2'b01,
    ST_READ = 2'b10
  } phcp_state_t;

  // pin group as seen after synchronisation
  typedef struct packed {
    logic select_n;
    logic addr;
    logic strobe_a_n;
    logic strobe_b;
    logic [15:0] data;
  } phcp_pins_t;

  localparam int PIN_W = $bits(phcp_pins_t);
  localparam logic [PIN_W-1:0] PIN_RST = {4'hf, 16'h0000};

  // static configuration
  typedef struct packed {
    logic combined_strobe;
    logic bus_16;
    logic byte_swap;
    logic wait_enable;
    logic wait_active_high;
    logic wait_push_pull;
  } phcp_cfg_t;

  localparam logic [5:0] CFG_RST = 6'h00;
endpackage
`default_nettype wire

// >>> logic/phcp_port.sv
`default_nettype none

module phcp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic push, pop, full, empty;

  assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign empty = (wr_ptr_reg == rd_ptr_reg);
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem_reg[rd_ptr_reg[AW-1:0]];
  assign push = in_valid_i && !full;
  assign pop = out_ready_i && !empty;

  always_comb begin
    wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
    rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
    end
    if (push) begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_i;
    end
  end
endmodule

module phcp_port #(
  parameter int CNT_W = 16,
  parameter int FIFO_DEPTH_P = phcp_pkg::FIFO_DEPTH
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire phcp_pkg::phcp_cfg_t cfg_i,
  input wire logic port_select_n_i,
  input wire logic port_addr_i,
  input wire logic write_strobe_n_i,
  input wire logic read_strobe_n_i,
  input wire logic [15:0] port_data_bus_i,
  output logic [15:0] port_data_bus_o,
  output logic [1:0] port_data_bus_oe_o,
  output logic hold_off_out_o,
  output logic hold_off_out_oe_o,
  output logic cmd_valid_o,
  output logic [15:0] cmd_word_o,
  input wire logic [CNT_W-1:0] cmd_words_i,
  input wire logic cmd_is_read_i,
  output logic wr_valid_o,
  input wire logic wr_ready_i,
  output logic [15:0] wr_data_o,
  input wire logic rd_valid_i,
  output logic rd_ready_o,
  input wire logic [15:0] rd_data_i,
  input wire logic [7:0] active_page_number_i,
  input wire logic interrupt_level_i,
  output logic command_in_progress_o
);
  import phcp_pkg::*;

  logic [PIN_W-1:0] sync_reg [SYNC_STAGES];
  logic [PIN_W-1:0] filt_reg, filt_next;
  phcp_pins_t pins, prev_reg;
  phcp_cfg_t cfg_reg;
  phcp_state_t state_reg, state_next;
  logic wr_act, rd_act;
  logic phase_reg, phase_next, stat_phase_reg, stat_phase_next;
  logic cmd_col_reg, cmd_col_next;
  logic [7:0] first_byte_reg, first_byte_next;
  logic [CNT_W-1:0] remaining_reg, remaining_next;
  logic cmd_read_reg, cmd_read_next, first_pend_reg, first_pend_next;
  logic cmd_valid_reg, cmd_valid_next;
  logic [15:0] cmd_word_reg, cmd_word_next;
  logic [15:0] rd_hold_reg, rd_hold_next;
  logic rd_hold_valid_reg, rd_hold_valid_next;
  logic rd_is_data_reg, rd_is_data_next;
  logic [15:0] dout_reg, dout_next;
  logic [1:0] doe_reg, doe_next;
  logic hold_reg, hold_next;
  logic fifo_push, fifo_ready;
  logic [15:0] fifo_word;
  logic [15:0] status_word, rd_word;
  logic rd_fetch, busy;

  // three-stage synchroniser; a pin change is taken once stages two and three agree
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      for (int i = 0; i < SYNC_STAGES; i++) begin
        sync_reg[i] <= PIN_RST;
      end
    end else begin
      sync_reg[0] <= {port_select_n_i, port_addr_i, write_strobe_n_i, read_strobe_n_i,
                      port_data_bus_i};
      for (int i = 1; i < SYNC_STAGES; i++) begin
        sync_reg[i] <= sync_reg[i-1];
      end
    end
  end

  always_comb begin
    filt_next = (~(sync_reg[1] ^ sync_reg[2]) & sync_reg[2]) |
                ((sync_reg[1] ^ sync_reg[2]) & filt_reg);
  end

  assign pins = phcp_pins_t'(filt_reg);

  // access qualifiers: select low plus strobe(s) low; in combined mode a read has strobe_b high
  always_comb begin
    if (cfg_reg.combined_strobe) begin
      wr_act = !pins.select_n && !pins.strobe_a_n && !pins.strobe_b;
      rd_act = !pins.select_n && !pins.strobe_a_n && pins.strobe_b;
    end else begin
      wr_act = !pins.select_n && !pins.strobe_a_n;
      rd_act = !pins.select_n && !pins.strobe_b;
    end
  end

  assign status_word = {active_page_number_i, 5'h00, busy, interrupt_level_i,
                        hold_off_out_o};
  assign busy = (remaining_reg != '0);
  // swapped view of the held read word, data only
  assign rd_word = cfg_reg.byte_swap ? {rd_hold_reg[7:0], rd_hold_reg[15:8]} : rd_hold_reg;
  assign rd_fetch = rd_valid_i && rd_ready_o;

  always_comb begin
    state_next = state_reg;
    phase_next = phase_reg;
    stat_phase_next = stat_phase_reg;
    cmd_col_next = cmd_col_reg;
    first_byte_next = first_byte_reg;
    remaining_next = remaining_reg;
    cmd_read_next = cmd_read_reg;
    first_pend_next = first_pend_reg;
    cmd_valid_next = 1'b0;
    cmd_word_next = cmd_word_reg;
    rd_hold_next = rd_hold_reg;
    rd_hold_valid_next = rd_hold_valid_reg;
    rd_is_data_next = rd_is_data_reg;
    dout_next = dout_reg;
    hold_next = 1'b0;
    fifo_push = 1'b0;
    fifo_word = DATA_RST;
    // a new command's data count arrives with its pulse
    if (cmd_valid_reg) begin
      remaining_next = cmd_words_i;
      cmd_read_next = cmd_is_read_i;
      first_pend_next = cmd_is_read_i;
    end
    if (rd_fetch) begin
      rd_hold_next = rd_data_i;
      rd_hold_valid_next = 1'b1;
    end
    case (state_reg)
      ST_IDLE: begin
        if (wr_act) begin
          state_next = ST_WRITE;
        end else if (rd_act) begin
          state_next = ST_READ;
          rd_is_data_next = !pins.addr;
        end
      end
      ST_WRITE: begin
        // data sits behind the FIFO; stall the host while it is full
        hold_next = !prev_reg.addr && busy && !fifo_ready;
        if (!wr_act) begin
          // rising edge of the write strobe latches the word
          state_next = ST_IDLE;
          if (prev_reg.addr && !(phase_reg && cmd_col_reg && !cfg_reg.bus_16)) begin
            // address-high write restarts the interpreter
            remaining_next = '0;
            cmd_read_next = 1'b0;
            first_pend_next = 1'b0;
            rd_hold_valid_next = 1'b0;
            stat_phase_next = 1'b0;
            phase_next = 1'b0;
          end
          if (cfg_reg.bus_16) begin
            if (prev_reg.addr || (!busy && !cmd_valid_reg)) begin
              cmd_valid_next = 1'b1;
              cmd_word_next = prev_reg.data;
            end else begin
              fifo_push = 1'b1;
              fifo_word = cfg_reg.byte_swap ? {prev_reg.data[7:0], prev_reg.data[15:8]}
                                            : prev_reg.data;
              remaining_next = remaining_reg - 1'b1;
            end
          end else if (!phase_reg || (prev_reg.addr && !cmd_col_reg)) begin
            // narrow bus: first byte of a pair
            phase_next = 1'b1;
            first_byte_next = prev_reg.data[7:0];
            cmd_col_next = prev_reg.addr || (!busy && !cmd_valid_reg);
          end else begin
            phase_next = 1'b0;
            if (cmd_col_reg) begin
              cmd_valid_next = 1'b1;
              cmd_word_next = {first_byte_reg, prev_reg.data[7:0]};
            end else begin
              fifo_push = 1'b1;
              fifo_word = cfg_reg.byte_swap ? {prev_reg.data[7:0], first_byte_reg}
                                            : {first_byte_reg, prev_reg.data[7:0]};
              remaining_next = remaining_reg - 1'b1;
            end
          end
        end
      end
      ST_READ: begin
        if (rd_is_data_reg) begin
          // wait only while the requested word has not arrived
          hold_next = !rd_hold_valid_reg && cmd_read_reg && busy;
          if (cfg_reg.bus_16 || !phase_reg) begin
            dout_next = cfg_reg.bus_16 ? rd_word : {BYTE_RST, rd_word[15:8]};
          end else begin
            dout_next = {BYTE_RST, rd_word[7:0]};
          end
        end else begin
          // status read is stretched until the first read word is ready
          hold_next = first_pend_reg && !rd_hold_valid_reg && busy;
          if (cfg_reg.bus_16 || !stat_phase_reg) begin
            dout_next = cfg_reg.bus_16 ? status_word
                                       : {BYTE_RST, status_word[15:8]};
          end else begin
            dout_next = {BYTE_RST, status_word[7:0]};
          end
        end
        if (!rd_act) begin
          state_next = ST_IDLE;
          if (!rd_is_data_reg) begin
            // status read leaves the interpreter alone
            stat_phase_next = !cfg_reg.bus_16 && !stat_phase_reg;
          end else if (rd_hold_valid_reg && cmd_read_reg && busy) begin
            first_pend_next = 1'b0;
            if (cfg_reg.bus_16 || phase_reg) begin
              phase_next = 1'b0;
              rd_hold_valid_next = 1'b0;
              remaining_next = remaining_reg - 1'b1;
            end else begin
              phase_next = 1'b1;
            end
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (!cfg_reg.wait_enable) begin
      hold_next = 1'b0;
    end
    // bus driven only during a read, low lane only when narrow
    if (state_next == ST_READ) begin
      doe_next = cfg_reg.bus_16 ? LANE_OE_WIDE : LANE_OE_NARROW;
    end else begin
      doe_next = LANE_OE_RST;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      filt_reg <= PIN_RST;
      prev_reg <= phcp_pins_t'(PIN_RST);
      cfg_reg <= phcp_cfg_t'(CFG_RST);
      state_reg <= ST_IDLE;
      phase_reg <= 1'b0;
      stat_phase_reg <= 1'b0;
      cmd_col_reg <= 1'b0;
      first_byte_reg <= BYTE_RST;
      remaining_reg <= '0;
      cmd_read_reg <= 1'b0;
      first_pend_reg <= 1'b0;
      cmd_valid_reg <= 1'b0;
      cmd_word_reg <= DATA_RST;
      rd_hold_reg <= DATA_RST;
      rd_hold_valid_reg <= 1'b0;
      rd_is_data_reg <= 1'b0;
      dout_reg <= DATA_RST;
      doe_reg <= LANE_OE_RST;
      hold_reg <= 1'b0;
    end else begin
      filt_reg <= filt_next;
      prev_reg <= pins;
      cfg_reg <= cfg_i;
      state_reg <= state_next;
      phase_reg <= phase_next;
      stat_phase_reg <= stat_phase_next;
      cmd_col_reg <= cmd_col_next;
      first_byte_reg <= first_byte_next;
      remaining_reg <= remaining_next;
      cmd_read_reg <= cmd_read_next;
      first_pend_reg <= first_pend_next;
      cmd_valid_reg <= cmd_valid_next;
      cmd_word_reg <= cmd_word_next;
      rd_hold_reg <= rd_hold_next;
      rd_hold_valid_reg <= rd_hold_valid_next;
      rd_is_data_reg <= rd_is_data_next;
      dout_reg <= dout_next;
      doe_reg <= doe_next;
      hold_reg <= hold_next;
    end
  end

  phcp_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH_P)
  ) u_wr_fifo (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .in_valid_i(fifo_push),
    .in_ready_o(fifo_ready),
    .in_data_i(fifo_word),
    .out_valid_o(wr_valid_o),
    .out_ready_i(wr_ready_i),
    .out_data_o(wr_data_o)
  );

  // hold-off pin: polarity and open-drain/push-pull, undriven until enabled
  assign hold_off_out_o = cfg_reg.wait_active_high ? hold_reg : !hold_reg;
  assign hold_off_out_oe_o = cfg_reg.wait_enable && (cfg_reg.wait_push_pull || hold_reg);
  assign port_data_bus_o = dout_reg;
  assign port_data_bus_oe_o = doe_reg;
  assign cmd_valid_o = cmd_valid_reg;
  assign cmd_word_o = cmd_word_reg;
  assign rd_ready_o = !rd_hold_valid_reg && cmd_read_reg && busy;
  assign command_in_progress_o = busy;
endmodule
`default_nettype wire

// >>> test/phcp_port_chk.sv
`default_nettype none
module phcp_port_chk
  import phcp_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire phcp_pkg::phcp_cfg_t cfg_i,
  input wire logic write_strobe_n_i,
  input wire logic [15:0] port_data_bus_o,
  input wire logic [1:0] port_data_bus_oe_o,
  input wire logic hold_off_out_o,
  input wire logic hold_off_out_oe_o,
  input wire logic cmd_valid_o,
  input wire logic [CNT_W-1:0] cmd_words_i,
  input wire logic command_in_progress_o,
  input wire logic wr_valid_o,
  input wire logic wr_ready_i,
  input wire logic [15:0] wr_data_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // a long separate-mode write strobe: any read drive must be gone by now
  sequence seq_wr_held;
    (!write_strobe_n_i && !cfg_i.combined_strobe)[*8];
  endsequence
  sequence seq_cmd_load;
    cmd_valid_o && cmd_words_i != '0;
  endsequence
  a_rst_quiet: assert property ($fell(rst_i) |-> port_data_bus_oe_o == 2'b00
    && !hold_off_out_oe_o && !cmd_valid_o && !wr_valid_o) else $error("outputs active at reset");
  a_no_drive_wr: assert property (seq_wr_held |-> port_data_bus_oe_o == 2'b00)
    else $error("bus driven during write");
  a_oe_lanes: assert property (port_data_bus_oe_o != 2'b00
    |-> port_data_bus_oe_o == (cfg_i.bus_16 ? LANE_OE_WIDE : LANE_OE_NARROW))
    else $error("wrong lanes driven");
  a_narrow_upper: assert property (!cfg_i.bus_16 && port_data_bus_oe_o != 2'b00
    |-> port_data_bus_o[15:8] == 8'h00) else $error("upper byte not zero");
  a_hold_enable: assert property (!cfg_i.wait_enable |-> !hold_off_out_oe_o)
    else $error("hold-off driven while disabled");
  a_open_drain: assert property (hold_off_out_oe_o && !cfg_i.wait_push_pull
    |-> hold_off_out_o == cfg_i.wait_active_high) else $error("open drain drives inactive");
  a_push_pull: assert property (cfg_i.wait_enable && cfg_i.wait_push_pull
    && !$past(rst_i) && !$past(rst_i, 2) |-> hold_off_out_oe_o) else $error("push-pull idle");
  a_cmd_pulse: assert property (cmd_valid_o |=> !cmd_valid_o)
    else $error("command pulse too long");
  a_command_in_progress: assert property (seq_cmd_load |-> ##[1:2] command_in_progress_o)
    else $error("command not in progress");
  a_fifo_hold: assert property (wr_valid_o && !wr_ready_i
    |=> wr_valid_o && $stable(wr_data_o)) else $error("fifo output changed while stalled");
endmodule
bind phcp_port phcp_port_chk #(.CNT_W(CNT_W)) phcp_port_chk_i (.clk_sys_i, .rst_i, .cfg_i,
  .write_strobe_n_i, .port_data_bus_o, .port_data_bus_oe_o, .hold_off_out_o, .hold_off_out_oe_o,
  .cmd_valid_o, .cmd_words_i, .command_in_progress_o, .wr_valid_o, .wr_ready_i, .wr_data_o);
`default_nettype wire

// >>> test/phcp_host_model.sv
`default_nettype none
module phcp_host_model
  import phcp_pkg::*;
(
  input wire logic clk_sys_i,
  input wire phcp_pkg::phcp_cfg_t cfg_i,
  input wire logic hold_i,
  input wire logic [15:0] bus_i,
  output logic sel_n_o,
  output logic addr_o,
  output logic wr_n_o,
  output logic rd_n_o,
  output logic [15:0] bus_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sel_n_o = 1'b1;
    addr_o = 1'b0;
    wr_n_o = 1'b1;
    rd_n_o = 1'b1;
    bus_o = 16'h5a5a;
  end
  task automatic xfer(input logic a, input logic rd, input logic [15:0] d, output logic [15:0] q);
    int n;
    @(negedge clk_sys_i);
    sel_n_o = 1'b0;
    addr_o = a;
    bus_o = rd ? ~d : d;
    if (cfg_i.combined_strobe) begin
      rd_n_o = rd;
      wr_n_o = 1'b0;
    end else if (rd) begin
      rd_n_o = 1'b0;
    end else begin
      wr_n_o = 1'b0;
    end
    repeat (8) @(negedge clk_sys_i);
    n = 0;
    // hold the access while the device holds us off
    while (cfg_i.wait_enable && hold_i === cfg_i.wait_active_high && n < 400) begin
      @(negedge clk_sys_i);
      n++;
    end
    repeat (2) @(negedge clk_sys_i);
    @(posedge clk_sys_i);
    q = bus_i;
    @(negedge clk_sys_i);
    sel_n_o = 1'b1;
    wr_n_o = 1'b1;
    rd_n_o = 1'b1;
    bus_o = ~bus_o;
    repeat (6) @(negedge clk_sys_i);
  endtask
endmodule
`default_nettype wire

// >>> test/phcp_port_bench.sv
`default_nettype none
module phcp_port_bench;
  import phcp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  phcp_cfg_t cfg = CFG_RST;
  phcp_cfg_t cfgs[4] = '{6'h15, 6'h2e, 6'h04, 6'h39};
  logic sel_n, addr, wr_n, rd_n, hold_o, hold_oe, cmd_valid, wr_valid, rd_ready, prog, hold_w;
  logic [1:0] oe;
  logic [15:0] hbus, dout, bus_w, cmd_word, wr_data, q;
  logic [15:0] cmd_words = 16'h0000;
  logic [15:0] rd_data = 16'h1234;
  logic [7:0] page = 8'h00;
  logic cmd_is_read = 1'b0, wr_ready = 1'b0, rd_valid = 1'b0, rd_en = 1'b0, stall = 1'b0;
  logic intl = 1'b0, saw_hold = 1'b0, popped = 1'b0;
  int fail_count = 0, n_compared = 0, cyc = 0;
  logic [15:0] cmdq[$], ecq[$], wrq[$], dq[$], rdq[$];
  assign bus_w = {oe[1] ? dout[15:8] : hbus[15:8], oe[0] ? dout[7:0] : hbus[7:0]};
  assign hold_w = hold_oe ? hold_o : ~cfg.wait_active_high;
  phcp_port phcp_port_i (.clk_sys_i, .rst_i, .cfg_i(cfg), .port_select_n_i(sel_n),
    .port_addr_i(addr), .write_strobe_n_i(wr_n), .read_strobe_n_i(rd_n),
    .port_data_bus_i(bus_w), .port_data_bus_o(dout), .port_data_bus_oe_o(oe),
    .hold_off_out_o(hold_o), .hold_off_out_oe_o(hold_oe), .cmd_valid_o(cmd_valid),
    .cmd_word_o(cmd_word), .cmd_words_i(cmd_words), .cmd_is_read_i(cmd_is_read),
    .wr_valid_o(wr_valid), .wr_ready_i(wr_ready), .wr_data_o(wr_data), .rd_valid_i(rd_valid),
    .rd_ready_o(rd_ready), .rd_data_i(rd_data), .active_page_number_i(page),
    .interrupt_level_i(intl), .command_in_progress_o(prog));
  phcp_host_model phcp_host_model_i (.clk_sys_i, .cfg_i(cfg), .hold_i(hold_w), .bus_i(bus_w),
    .sel_n_o(sel_n), .addr_o(addr), .wr_n_o(wr_n), .rd_n_o(rd_n), .bus_o(hbus));
  initial forever #10 clk_sys_i = ~clk_sys_i;
  task automatic finish_test();
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cmd_valid === 1'b1) cmdq.push_back(cmd_word);
    if (wr_valid === 1'b1 && wr_ready) wrq.push_back(wr_data);
    if (cfg.wait_enable && hold_w === cfg.wait_active_high) saw_hold = 1'b1;
    popped = rd_valid && rd_ready === 1'b1;
    if (popped) rdq.push_back(rd_data);
    if (cyc == 40000) begin
      fail_count++;
      finish_test();
    end
  end
  always @(negedge clk_sys_i) begin
    wr_ready <= ~stall & 1'($urandom_range(1));
    rd_valid <= rd_en;
    if (popped) rd_data <= 16'($urandom);
  end
  function automatic logic [15:0] sw16(input logic [15:0] d, input logic s);
    return s ? {d[7:0], d[15:8]} : d;
  endfunction
  function automatic logic [15:0] stat_exp(input logic busy);
    return {page, 5'h00, busy, intl, ~cfg.wait_active_high};
  endfunction
  task automatic acc(input logic a, input logic rd, input logic [15:0] d, output logic [15:0] r);
    logic s;
    logic [15:0] p, b0, b1;
    s = !a && cfg.byte_swap;
    p = sw16(d, s);
    if (cfg.bus_16) begin
      phcp_host_model_i.xfer(a, rd, p, b0);
      r = sw16(b0, s);
    end else begin
      // upper lane carries junk: only the low byte may count
      phcp_host_model_i.xfer(a, rd, {p[7:0], p[15:8]}, b0);
      phcp_host_model_i.xfer(a, rd, p, b1);
      r = sw16({b0[7:0], b1[7:0]}, s);
    end
  endtask
  task automatic cmd(input logic [15:0] w, input logic [15:0] n);
    cmd_words = n;
    cmd_is_read = 1'b0;
    ecq.push_back(w);
    // address pin raised on every byte of the command word that opens each write sequence
    acc(1'b1, 1'b0, w, q);
  endtask
  task automatic dat(input logic [15:0] d);
    dq.push_back(d);
    acc(1'b0, 1'b0, d, q);
  endtask
  task automatic drain();
    int n;
    n = 0;
    while (wrq.size() < dq.size() && n < 400) begin
      @(negedge clk_sys_i);
      n++;
    end
    // a write side that never empties is a failure in itself
    if (n >= 400) fail_count++;
  endtask
  task automatic suite(input phcp_cfg_t c);
    logic [15:0] w;
    @(negedge clk_sys_i);
    rst_i = 1'b1;
    cfg = c;
    rd_en = 1'b0;
    page = 8'($urandom);
    intl = 1'($urandom);
    repeat (2) @(negedge clk_sys_i);
    rst_i = 1'b0;
    check({14'h0000, oe}, 16'h0000);
    check({15'h0000, hold_oe}, 16'h0000);
    cmdq.delete();
    ecq.delete();
    wrq.delete();
    dq.delete();
    rdq.delete();
    cmd(16'($urandom), 16'h0002);
    dat(16'($urandom));
    dat(16'($urandom));
    w = 16'($urandom);
    cmd_words = 16'h0001;
    cmd_is_read = 1'b1;
    ecq.push_back(sw16(w, c.byte_swap));
    acc(1'b0, 1'b0, w, q);
    saw_hold = 1'b0;
    fork
      begin
        repeat (60) @(negedge clk_sys_i);
        rd_en = 1'b1;
      end
    join_none
    acc(1'b1, 1'b1, 16'h0000, q);
    check(q, stat_exp(1'b1));
    check({15'h0000, saw_hold}, {15'h0000, c.wait_enable});
    if (!c.wait_enable) begin
      // no hold-off pin in use: the host polls the status word instead
      repeat (80) @(negedge clk_sys_i);
      acc(1'b1, 1'b1, 16'h0000, q);
      check(q, stat_exp(1'b1));
    end
    acc(1'b0, 1'b1, 16'h0000, q);
    check(q, rdq.size() > 0 ? rdq[0] : ~q);
    check({15'h0000, prog}, 16'h0000);
    cmd(16'($urandom), 16'h0002);
    dat(16'($urandom));
    acc(1'b1, 1'b1, 16'h0000, q);
    check(q, stat_exp(1'b1));
    dat(16'($urandom));
    check({15'h0000, prog}, 16'h0000);
    cmd(16'($urandom), 16'h0003);
    dat(16'($urandom));
    cmd(16'($urandom), 16'h0001);
    dat(16'($urandom));
    check({15'h0000, prog}, 16'h0000);
    drain();
    stall = 1'b1;
    // the stretched status read above must not count as a write stall
    saw_hold = 1'b0;
    cmd(16'($urandom), 16'h0011);
    repeat (15) dat(16'($urandom));
    check({15'h0000, saw_hold}, 16'h0000);
    dat(16'($urandom));
    fork
      begin
        repeat (100) @(negedge clk_sys_i);
        stall = 1'b0;
      end
    join_none
    dat(16'($urandom));
    if (!c.wait_enable) void'(dq.pop_back());
    check({15'h0000, saw_hold}, {15'h0000, c.wait_enable});
    drain();
    check(16'(cmdq.size()), 16'(ecq.size()));
    foreach (ecq[i]) if (i < cmdq.size()) check(cmdq[i], ecq[i]);
    check(16'(wrq.size()), 16'(dq.size()));
    foreach (dq[i]) if (i < wrq.size()) check(wrq[i], dq[i]);
    $display("config %h done, mismatches so far %0d", c, fail_count);
  endtask
  initial begin
    void'($urandom(55));
    foreach (cfgs[i]) suite(cfgs[i]);
    finish_test();
  end
endmodule
`default_nettype wire
